//--- verilog/rgt_defs.svh
// Constants for the real-time gain tuning control block
//
// Contract
// - Tuning may run in every control mode, never restricted by mode.
// - Adaptive notch filter operates only when control mode equals 2.
// - Mode 0 off; 1-3 tune with filter; 4-6 tune only; 7 filter only.
// - Tuning-mode setting defaults to 1 until changed.
// - Changed tuning mode applies only at power-on or servo-enable rising edge.
// - Tuning activates at servo enable unless mode is 0 or 7; here it is on from reset release, servo pin not checked.
// - While filter effective, estimate resonance and set notch coefficient.
// - While tuning, gains, filters, inertia ratio and notch frequency auto-update; here notch frequency updates only while filter active.
// - While tuning, force fixed companion values 300,50,1,10,30,50,33,20.
// - While tuning, refuse external writes to auto-tuned parameters.
// - Save inertia ratio and notch frequency to NVM every 30 minutes while tuning.
// - At power-up, start tuning from saved inertia ratio and notch frequency.
`ifndef RGT_DEFS_SVH
`define RGT_DEFS_SVH

`define RGT_MODE_RESET      3'h1
`define RGT_CTRL_HIFUNC     2'h2
`define RGT_FIX_VFF         16'h012c
`define RGT_FIX_FF_FILT     16'h0032
`define RGT_FIX_GAIN2_ACT   16'h0001
`define RGT_FIX_SW_MODE     16'h000a
`define RGT_FIX_SW_DELAY    16'h001e
`define RGT_FIX_SW_LEVEL    16'h0032
`define RGT_FIX_SW_HYST     16'h0021
`define RGT_FIX_GSW_TIME    16'h0014
`define RGT_SAVE_MINUTES    30
`define RGT_CLK_HZ          10000000
`define RGT_SAVE_CYCLES     (`RGT_SAVE_MINUTES * 64'h3c * `RGT_CLK_HZ)
`define RGT_PAR_W           16

`endif

//--- verilog/rgt_pkg.sv
// Types for the real-time gain tuning control block
`default_nettype none
`include "rgt_defs.svh"
package rgt_pkg;
    typedef enum logic [2:0] {
        RGT_M_OFF    = 3'b000,
        RGT_M_F_LOW  = 3'b001,
        RGT_M_F_MID  = 3'b010,
        RGT_M_F_HIGH = 3'b011,
        RGT_M_N_LOW  = 3'b100,
        RGT_M_N_MID  = 3'b101,
        RGT_M_N_HIGH = 3'b110,
        RGT_M_FILT   = 3'b111
    } rgt_mode_t;

    typedef enum logic [1:0] {
        RGT_CH_NONE = 2'b00,
        RGT_CH_LOW  = 2'b01,
        RGT_CH_MID  = 2'b10,
        RGT_CH_HIGH = 2'b11
    } rgt_change_t;

    typedef struct packed {
        logic        tune_on;
        logic        filt_req;
        rgt_change_t change;
    } rgt_decode_t;

    typedef struct packed {
        logic [15:0] vff;
        logic [15:0] ff_filt;
        logic [15:0] gain2_act;
        logic [15:0] sw_mode;
        logic [15:0] sw_delay;
        logic [15:0] sw_level;
        logic [15:0] sw_hyst;
        logic [15:0] gsw_time;
    } rgt_fixed_t;

    typedef struct packed {
        logic [15:0] inertia;
        logic [15:0] notch;
    } rgt_est_t;
endpackage : rgt_pkg
`default_nettype wire

//--- verilog/rgt_save_timer.sv
// Periodic save timer for tuned results
`default_nettype none
`include "rgt_defs.svh"
module rgt_save_timer
    import rgt_pkg::*;
#(
    parameter longint unsigned PERIOD = `RGT_SAVE_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    localparam int CW = $clog2(PERIOD + 1) > 0 ? $clog2(PERIOD + 1) : 1;
    initial begin
        if (PERIOD < 1) begin
            $error("PERIOD must be at least 1");
        end
    end

    logic [CW-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Counts while tuning, one pulse each period
    always_ff @(posedge ref_clk) begin
        if (rst || !run) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(PERIOD - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + CW'(1);
            tick  <= 1'b0;
        end
    end
endmodule : rgt_save_timer
`default_nettype wire

//--- verilog/rgt_notch_est.sv
// Resonance frequency tracker for the adaptive notch filter
`default_nettype none
`include "rgt_defs.svh"
module rgt_notch_est
    import rgt_pkg::*;
#(
    parameter int W = `RGT_PAR_W
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         enable,
    input  wire logic         load,
    input  wire logic [W-1:0] init_freq,
    input  wire logic         vib_valid,
    input  wire logic [W-1:0] vib_freq,
    output logic [W-1:0]      freq,
    output logic [W-1:0]      coef
);
    initial begin
        if (W < 4) begin
            $error("W too small");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency tracks vibration by halving the gap
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            freq <= '0;
        end else if (load) begin
            freq <= init_freq;
        end else if (enable && vib_valid) begin
            freq <= W'((({1'b0, freq} + {1'b0, vib_freq}) >> 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coefficient follows frequency, zero when filter inactive
    always_ff @(posedge ref_clk) begin
        if (rst || !enable) begin
            coef <= '0;
        end else begin
            coef <= freq;
        end
    end
endmodule : rgt_notch_est
`default_nettype wire

//--- verilog/rgt_tuning_ctrl.sv
// Top of the real-time gain tuning control block
`default_nettype none
`include "rgt_defs.svh"
module rgt_tuning_ctrl
    import rgt_pkg::*;
#(
    parameter int              W           = `RGT_PAR_W,
    parameter longint unsigned SAVE_CYCLES = `RGT_SAVE_CYCLES
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         servo_on_pin,
    input  wire logic [1:0]   control_mode_select,
    input  wire logic         mode_wr,
    input  wire logic [2:0]   mode_wdata,
    input  wire logic [3:0]   machine_stiffness_level,
    input  wire logic [W-1:0] nvm_load_inertia_ratio,
    input  wire logic [W-1:0] nvm_notch_frequency_estimate,
    input  wire logic         est_valid,
    input  wire logic [W-1:0] est_inertia,
    input  wire logic         vib_valid,
    input  wire logic [W-1:0] vib_freq,
    input  wire logic         par_wr,
    input  wire logic         par_wr_auto,
    output logic [2:0]        tuning_mode_setting,
    output logic [2:0]        active_mode,
    output logic              tune_active,
    output logic              filter_active,
    output logic [1:0]        change_rate,
    output logic [3:0]        stiffness,
    output logic [W-1:0]      load_inertia_ratio,
    output logic [W-1:0]      notch_frequency_estimate,
    output logic [W-1:0]      notch_coef,
    output rgt_fixed_t        fixed_vals,
    output logic              fixed_force,
    output logic              par_wr_ok,
    output logic              par_wr_refused,
    output logic              nvm_save,
    output rgt_est_t          nvm_save_data
);
    initial begin
        if (W < 4) begin
            $error("W too small");
        end
        if (W > 16) begin
            $error("W wider than the saved record");
        end
        if (SAVE_CYCLES < 1) begin
            $error("SAVE_CYCLES must be at least 1");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    function automatic rgt_decode_t decode_mode(input logic [2:0] m);
        rgt_decode_t d;
        d = '0;
        unique case (rgt_mode_t'(m))
            RGT_M_OFF: begin
                d = '0;
            end
            RGT_M_F_LOW, RGT_M_F_MID, RGT_M_F_HIGH: begin
                d.tune_on  = 1'b1;
                d.filt_req = 1'b1;
                d.change   = rgt_change_t'(m[1:0]);
            end
            RGT_M_N_LOW: begin
                d.tune_on = 1'b1;
                d.change  = RGT_CH_LOW;
            end
            RGT_M_N_MID: begin
                d.tune_on = 1'b1;
                d.change  = RGT_CH_MID;
            end
            RGT_M_N_HIGH: begin
                d.tune_on = 1'b1;
                d.change  = RGT_CH_HIGH;
            end
            RGT_M_FILT: begin
                d.filt_req = 1'b1;
            end
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detect
    logic sync1_q;
    logic sync2_q;
    logic servo_q;
    logic servo_rise;
    logic boot_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= servo_on_pin;
            sync2_q <= sync1_q;
        end
    end

    // Delayed copy for the rising edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            servo_q <= 1'b0;
        end else begin
            servo_q <= sync2_q;
        end
    end

    assign servo_rise = sync2_q && !servo_q;

    // First cycle after reset release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Written setting and active mode
    logic        apply;
    rgt_decode_t dec;

    assign apply = boot_q || servo_rise;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tuning_mode_setting <= `RGT_MODE_RESET;
        end else if (mode_wr) begin
            tuning_mode_setting <= mode_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_mode <= `RGT_MODE_RESET;
        end else if (apply) begin
            active_mode <= tuning_mode_setting;
        end
    end

    assign dec = decode_mode(active_mode);

    ////////////////////////////////////////////////////////////////////////
    // Enables, no mode gate on tuning
    logic filt_en;

    assign filt_en = dec.filt_req && (control_mode_select == `RGT_CTRL_HIFUNC);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tune_active <= 1'b0;
        end else begin
            tune_active <= dec.tune_on && !boot_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            filter_active <= 1'b0;
        end else begin
            filter_active <= filt_en && !boot_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            change_rate <= 2'h0;
        end else begin
            change_rate <= dec.change;
        end
    end

    // Stiffness level passed on to the gain tables
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stiffness <= 4'h0;
        end else begin
            stiffness <= machine_stiffness_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Inertia ratio estimate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            load_inertia_ratio <= '0;
        end else if (boot_q) begin
            load_inertia_ratio <= nvm_load_inertia_ratio;
        end else if (tune_active && est_valid) begin
            load_inertia_ratio <= est_inertia;
        end
    end

    rgt_notch_est #(
        .W (W)
    ) u_notch (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .enable    (filter_active),
        .load      (boot_q),
        .init_freq (nvm_notch_frequency_estimate),
        .vib_valid (vib_valid),
        .vib_freq  (vib_freq),
        .freq      (notch_frequency_estimate),
        .coef      (notch_coef)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fixed companion values, word 7 is the top field
    function automatic logic [15:0] fixed_word(input logic [2:0] k);
        logic [15:0] v;
        v = 16'h0000;
        unique case (k)
            3'h7: v = `RGT_FIX_VFF;
            3'h6: v = `RGT_FIX_FF_FILT;
            3'h5: v = `RGT_FIX_GAIN2_ACT;
            3'h4: v = `RGT_FIX_SW_MODE;
            3'h3: v = `RGT_FIX_SW_DELAY;
            3'h2: v = `RGT_FIX_SW_LEVEL;
            3'h1: v = `RGT_FIX_SW_HYST;
            3'h0: v = `RGT_FIX_GSW_TIME;
        endcase
        return v;
    endfunction

    logic [15:0] fixed_q [8];

    for (genvar k = 0; k < 8; k++) begin : g_fixed
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                fixed_q[k] <= 16'h0000;
            end else begin
                fixed_q[k] <= fixed_word(3'(k));
            end
        end
    end

    assign fixed_vals = {fixed_q[7], fixed_q[6], fixed_q[5], fixed_q[4],
                         fixed_q[3], fixed_q[2], fixed_q[1], fixed_q[0]};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fixed_force <= 1'b0;
        end else begin
            fixed_force <= dec.tune_on && !boot_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External parameter write gate
    logic refuse;

    assign refuse = par_wr_auto && tune_active;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            par_wr_ok <= 1'b0;
        end else begin
            par_wr_ok <= par_wr && !refuse;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            par_wr_refused <= 1'b0;
        end else begin
            par_wr_refused <= par_wr && refuse;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Periodic save of inertia and notch frequency
    logic save_tick;

    rgt_save_timer #(
        .PERIOD (SAVE_CYCLES)
    ) u_save (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (tune_active),
        .tick    (save_tick)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nvm_save <= 1'b0;
        end else begin
            nvm_save <= save_tick;
        end
    end

    // Record holds until the next save
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nvm_save_data <= '0;
        end else if (save_tick) begin
            nvm_save_data.inertia <= 16'(load_inertia_ratio);
            nvm_save_data.notch   <= 16'(notch_frequency_estimate);
        end
    end
endmodule : rgt_tuning_ctrl
`default_nettype wire

//--- tb/rgt_tuning_ctrl_properties.sv
// Port checker of the tuning control block
`default_nettype none
module rgt_tuning_ctrl_properties
    import rgt_pkg::*;
#(
    parameter longint unsigned SAVE_CYCLES = 20
) (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       servo_on_pin,
    input wire logic [1:0] control_mode_select,
    input wire logic       mode_wr,
    input wire logic [2:0] mode_wdata,
    input wire logic       par_wr,
    input wire logic       par_wr_auto,
    input wire logic [2:0] tuning_mode_setting,
    input wire logic [2:0] active_mode,
    input wire logic       tune_active,
    input wire logic       filter_active,
    input wire rgt_fixed_t fixed_vals,
    input wire logic       fixed_force,
    input wire logic       par_wr_ok,
    input wire logic       par_wr_refused,
    input wire logic       nvm_save,
    input wire logic       est_valid,
    input wire logic [15:0] est_inertia,
    input wire logic [15:0] load_inertia_ratio
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint LIM = 2 * longint'(SAVE_CYCLES) + 4;
    longint gap_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Cycles since last save while tuning
    always_ff @(posedge ref_clk) begin
        gap_q <= (rst || !tune_active || nvm_save) ? 0 : gap_q + 1;
    end
    a_tune_decode: assert property (tune_active |-> !($past(active_mode) inside {3'h0, 3'h7}))
        else $error("tuning on in an off mode");
    a_filter_mode: assert property (filter_active |-> $past(active_mode) inside {3'h1, 3'h2, 3'h3, 3'h7})
        else $error("filter on in a wrong mode");
    a_filter_ctrl: assert property (filter_active |-> $past(control_mode_select) == 2'h2)
        else $error("filter on outside positioning mode");
    a_fixed_vals: assert property (fixed_force |-> fixed_vals == {16'h012c, 16'h0032, 16'h0001, 16'h000a,
        16'h001e, 16'h0032, 16'h0021, 16'h0014})
        else $error("fixed values wrong");
    a_par_refuse: assert property (par_wr && par_wr_auto && tune_active |=> par_wr_refused && !par_wr_ok)
        else $error("tuned parameter write not refused");
    a_par_accept: assert property (par_wr && !(par_wr_auto && tune_active) |=> par_wr_ok && !par_wr_refused)
        else $error("legal write not accepted");
    a_mode_hold: assert property ($changed(active_mode) |-> $past(servo_on_pin, 3))
        else $error("active mode changed without servo on");
    a_setting_write: assert property (mode_wr |=> tuning_mode_setting == $past(mode_wdata))
        else $error("mode setting not written");
    a_save_gap: assert property (tune_active |-> gap_q < LIM)
        else $error("periodic save missing");
    a_inertia_track: assert property (est_valid && tune_active |=> load_inertia_ratio == $past(est_inertia))
        else $error("inertia estimate not taken");
endmodule // rgt_tuning_ctrl_properties

bind rgt_tuning_ctrl rgt_tuning_ctrl_properties #(.SAVE_CYCLES(SAVE_CYCLES)) rgt_props_inst (
    .ref_clk, .rst, .servo_on_pin, .control_mode_select, .mode_wr, .mode_wdata, .par_wr, .par_wr_auto,
    .tuning_mode_setting, .active_mode, .tune_active, .filter_active, .fixed_vals, .fixed_force,
    .par_wr_ok, .par_wr_refused, .nvm_save, .est_valid, .est_inertia, .load_inertia_ratio
);
`default_nettype wire

//--- tb/rgt_motor_model.sv
// Motor loop model giving inertia and vibration estimates
`default_nettype none
module rgt_motor_model #(
    parameter int GAP = 64
) (
    input wire logic     ref_clk,
    input wire logic     rst,
    output logic         est_valid,
    output logic [15:0]  est_inertia,
    output logic         vib_valid,
    output logic [15:0]  vib_freq
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_q;
    ////////////////////////////////////////
    // Rare pulses; data wanders between them
    always_ff @(posedge ref_clk) begin
        cnt_q <= (rst || cnt_q == GAP - 1) ? 0 : cnt_q + 1;
        est_valid <= !rst && cnt_q == GAP - 1;
        vib_valid <= !rst && cnt_q == GAP / 2;
        est_inertia <= 16'($urandom_range(1000, 50));
        vib_freq <= 16'($urandom_range(3000, 400));
    end
endmodule // rgt_motor_model
`default_nettype wire

//--- tb/rgt_tuning_ctrl_bench.sv
// Self-checking bench of the tuning control block
`default_nettype none
module rgt_tuning_ctrl_bench
    import rgt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [127:0] FIXV = {16'h012c, 16'h0032, 16'h0001, 16'h000a, 16'h001e, 16'h0032, 16'h0021, 16'h0014};
    logic        ref_clk, rst, servo_on_pin, mode_wr, par_wr, par_wr_auto, est_valid, vib_valid;
    logic        tune_active, filter_active, fixed_force, par_wr_ok, par_wr_refused, nvm_save;
    logic [1:0]  control_mode_select, change_rate;
    logic [2:0]  mode_wdata, tuning_mode_setting, active_mode;
    logic [3:0]  machine_stiffness_level, stiffness;
    logic [15:0] nvm_load_inertia_ratio, nvm_notch_frequency_estimate, est_inertia, vib_freq;
    logic [15:0] load_inertia_ratio, notch_frequency_estimate, notch_coef;
    rgt_fixed_t  fixed_vals;
    rgt_est_t    nvm_save_data;
    int          err_count, comparisons;
    rgt_tuning_ctrl #(.SAVE_CYCLES(20)) rgt_tuning_ctrl_inst (
        .ref_clk, .rst, .servo_on_pin, .control_mode_select, .mode_wr, .mode_wdata,
        .machine_stiffness_level, .nvm_load_inertia_ratio, .nvm_notch_frequency_estimate,
        .est_valid, .est_inertia, .vib_valid, .vib_freq, .par_wr, .par_wr_auto,
        .tuning_mode_setting, .active_mode, .tune_active, .filter_active, .change_rate,
        .stiffness, .load_inertia_ratio, .notch_frequency_estimate, .notch_coef,
        .fixed_vals, .fixed_force, .par_wr_ok, .par_wr_refused, .nvm_save, .nvm_save_data
    );
    rgt_motor_model rgt_motor_model_inst (.ref_clk, .rst, .est_valid, .est_inertia, .vib_valid, .vib_freq);
    ////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Inertia change class; zero when tuning is off
    function automatic logic [1:0] exp_rate(input logic [2:0] m);
        return (m == 3'h0 || m == 3'h7) ? 2'h0 : (m > 3'h3 ? 2'(m - 3'h3) : m[1:0]);
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        logic [2:0] m;
        logic [2:0] prev;
        int i;
        {servo_on_pin, mode_wr, mode_wdata, par_wr, par_wr_auto} = '0;
        {rst, control_mode_select, machine_stiffness_level} = {1'b1, 2'h2, 4'h5};
        nvm_load_inertia_ratio = 16'h1234;
        nvm_notch_frequency_estimate = 16'h0abc;
        err_count = 0;
        comparisons = 0;
        void'($urandom(58625));
        cyc(3);
        chk(tuning_mode_setting, 3'h1);
        rst = 1'b0;
        cyc(1);
        chk(active_mode, 3'h1);
        chk({load_inertia_ratio, notch_frequency_estimate}, 32'h12340abc);
        cyc(1);
        chk({tune_active, filter_active, fixed_force}, 3'h7);
        chk(fixed_vals, FIXV);
        for (i = 0; i < 40 && nvm_save !== 1'b1; i++) cyc(1);
        if (i == 40) begin
            err_count++;
        end
        chk(nvm_save_data, 32'h12340abc);
        chk(notch_coef, 16'h0abc);
        par_wr = 1'b1;
        for (i = 0; i < 6; i++) begin
            par_wr_auto = i[0];
            machine_stiffness_level = machine_stiffness_level + 4'($urandom_range(1, 0));
            cyc(1);
            chk({par_wr_refused, par_wr_ok}, {par_wr_auto, !par_wr_auto});
            chk(stiffness, machine_stiffness_level);
        end
        par_wr = 1'b0;
        for (i = 0; i < 14; i++) begin
            m = (i < 8) ? i[2:0] : 3'($urandom);
            prev = active_mode;
            servo_on_pin = 1'b0;
            cyc(3);
            mode_wr = 1'b1;
            mode_wdata = m;
            cyc(1);
            mode_wr = 1'b0;
            control_mode_select = i[0] ? 2'h2 : 2'($urandom);
            cyc(3);
            chk(tuning_mode_setting, m);
            chk(active_mode, prev);
            servo_on_pin = 1'b1;
            cyc(5);
            chk(active_mode, m);
            chk(change_rate, exp_rate(m));
            chk(tune_active, exp_rate(m) != 2'h0);
            chk(fixed_force, exp_rate(m) != 2'h0);
            chk(filter_active, control_mode_select == 2'h2 && m inside {3'h1, 3'h2, 3'h3, 3'h7});
            chk(notch_coef != 16'h0, control_mode_select == 2'h2 && m inside {3'h1, 3'h2, 3'h3, 3'h7});
            {par_wr, par_wr_auto} = 2'h3;
            cyc(1);
            par_wr = 1'b0;
            chk(par_wr_refused, exp_rate(m) != 2'h0);
        end
        stop_test();
    end
endmodule // rgt_tuning_ctrl_bench
`default_nettype wire
